//--- tb/test_timer_output_compare.sv
/* Self-checking bench for toc_top.
   Drives the register port and pins; pin load model on the far side. */
`timescale 1ns/100ps
`default_nettype none
module test_timer_output_compare
    import toc_pkg::*;
;
    logic              ref_clk_i;
    logic              rstn_i;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              wen, ren, idle, gate, flt_n, out, oe, freq, clr, pin, ext;
    logic [15:0]       hi;
    logic [DATA_W-1:0] v, v2;
    int                n_fail, num_checks, k, i;

    toc_top dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr), .wr_data_i(wdata),
        .wr_en_i(wen), .rd_en_i(ren), .rd_data_o(rdata), .idle_mode_i(idle), .ext_clk_i(ext),
        .gate_i(gate), .fault_n_i(flt_n), .compare_out_o(out), .compare_oe_o(oe));
    toc_pin_model pm_u (.ref_clk_i(ref_clk_i), .out_i(out), .oe_i(oe), .fault_req_i(freq),
        .clr_i(clr), .fault_n_o(flt_n), .pin_o(pin), .hi_cnt_o(hi));

    initial ref_clk_i = 1'b0;
    always #12.5 ref_clk_i = ~ref_clk_i;

    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wen <= 1'b1;
        @(posedge ref_clk_i);
        wen <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        ren <= 1'b1;
        @(posedge ref_clk_i);
        ren <= 1'b0;
        @(posedge ref_clk_i);
        d = rdata;
    endtask
    task automatic near(input logic [DATA_W-1:0] got, exp, input logic [7:0] tol);
        logic ok;
        ok = (got + tol >= exp) && (got <= exp + tol);
        num_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("BAD %0t got %0d want %0d", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        rd(a, d);
        near(d, exp, 8'h00);
    endtask
    task automatic wait_pin(input logic lv);
        cyc(2);
        for (i = 0; i < 400 && pin !== lv; i++) @(posedge ref_clk_i);
        near({31'h0, pin}, {31'h0, lv}, 8'h00);
        if (pin !== lv) give_verdict();
    endtask
    task automatic window(input int n);
        @(posedge ref_clk_i);
        clr <= 1'b1;
        @(posedge ref_clk_i);
        clr <= 1'b0;
        cyc(n);
    endtask

    initial begin
        n_fail = 0;
        num_checks = 0;
        {rstn_i, wen, ren, idle, gate, freq, clr, ext} = '0;
        addr = '0;
        wdata = '0;
        cyc(16);
        rstn_i <= 1'b1;
        rchk(ADDR_TMR2_PER, 32'h0000_FFFF);
        rchk(8'h3C, 32'h0);
        wr(ADDR_TMR2_CON, 32'hFFFF_FFFF);
        rchk(ADDR_TMR2_CON, 32'h0000_A07A);
        wr(ADDR_TMR3_CON, 32'hFFFF_FFFF);
        rchk(ADDR_TMR3_CON, 32'h0000_A072);
        wr(ADDR_TMR2_CON, 32'h0);
        wr(ADDR_TMR3_CON, 32'h0);
        wr(ADDR_OC_CON, 32'hFFFF_FFFF);
        rchk(ADDR_OC_CON, 32'h0000_A02F);
        wr(ADDR_OC_CON, 32'h0);
        for (k = 0; k < 8; k++) begin
            wr(ADDR_TMR2_CNT, 32'h0);
            wr(ADDR_TMR2_CON, 32'h8000 | 32'(k << PS_LSB));
            cyc(1024);
            wr(ADDR_TMR2_CON, 32'h0);
            rd(ADDR_TMR2_CNT, v);
            near(v, 32'(1026 >> ((k == 7) ? 8 : k)), 8'h02);
            cyc(20);
            rd(ADDR_TMR2_CNT, v2);
            near(v2, v, 8'h00);
        end
        idle <= 1'b1;
        wr(ADDR_TMR2_CNT, 32'h0);
        wr(ADDR_TMR2_CON, 32'h0000_A000);
        cyc(100);
        rchk(ADDR_TMR2_CNT, 32'h0);
        wr(ADDR_TMR2_CON, 32'h0000_8000);
        wr(ADDR_TMR2_CNT, 32'h0);
        cyc(100);
        rd(ADDR_TMR2_CNT, v);
        near(v, 32'd102, 8'h04);
        idle <= 1'b0;
        wr(ADDR_TMR2_CNT, 32'h0);
        wr(ADDR_TMR2_CON, 32'h0000_8080);
        cyc(100);
        rd(ADDR_TMR2_CNT, v);
        near(v, 32'h0, 8'h02);
        gate <= 1'b1;
        cyc(100);
        rd(ADDR_TMR2_CNT, v);
        near(v, 32'd102, 8'h06);
        wr(ADDR_TMR2_CON, 32'h0);
        gate <= 1'b0;
        wr(ADDR_TMR2_CNT, 32'h0);
        wr(ADDR_TMR2_CON, 32'h0000_8082);
        repeat (10) begin
            ext <= 1'b1;
            cyc(4);
            ext <= 1'b0;
            cyc(4);
        end
        wr(ADDR_TMR2_CON, 32'h0);
        rchk(ADDR_TMR2_CNT, 32'd10);
        idle <= 1'b1;
        wr(ADDR_TMR2_CNT, 32'h0000_FFF0);
        wr(ADDR_TMR3_CON, 32'h0);
        wr(ADDR_OC_PRI, 32'h0002_0005);
        wr(ADDR_OC_CON, 32'h0000_8021);
        wr(ADDR_TMR2_CON, 32'h0000_8008);
        cyc(60);
        near({31'h0, pin}, 32'h0, 8'h00);
        wr(ADDR_OC_PRI, 32'h0001_0050);
        wait_pin(1'b1);
        wr(ADDR_TMR2_CON, 32'h0);
        rchk(ADDR_TMR3_CNT, 32'h1);
        idle <= 1'b0;
        wr(ADDR_OC_CON, 32'h0);
        wr(ADDR_TMR3_PER, 32'h30);
        wr(ADDR_TMR3_CNT, 32'h0);
        wr(ADDR_TMR3_CON, 32'h0000_8000);
        wr(ADDR_OC_PRI, 32'h20);
        wr(ADDR_OC_CON, 32'h0000_8001);
        cyc(150);
        near({31'h0, pin}, 32'h0, 8'h00);
        wr(ADDR_OC_CON, 32'h0000_8009);
        wait_pin(1'b1);
        wr(ADDR_OC_CON, 32'h0000_800A);
        wait_pin(1'b0);
        wr(ADDR_OC_CON, 32'h0000_800B);
        wait_pin(1'b1);
        wait_pin(1'b0);
        wr(ADDR_TMR3_CON, 32'h0);
        wr(ADDR_TMR2_PER, 32'h9);
        wr(ADDR_TMR2_CNT, 32'h0);
        wr(ADDR_OC_PRI, 32'h2);
        wr(ADDR_OC_SEC, 32'h6);
        wr(ADDR_TMR2_CON, 32'h0000_8000);
        wr(ADDR_OC_CON, 32'h0000_8006);
        window(100);
        near({16'h0, hi}, 32'd60, 8'h05);
        wr(ADDR_OC_CON, 32'h0000_8007);
        freq <= 1'b1;
        cyc(20);
        near({31'h0, pin}, 32'h0, 8'h00);
        rchk(ADDR_OC_CON, 32'h0000_8017);
        freq <= 1'b0;
        cyc(30);
        rchk(ADDR_OC_CON, 32'h0000_8007);
        freq <= 1'b1;
        wr(ADDR_OC_CON, 32'h0000_8006);
        window(100);
        near({16'h0, hi}, 32'd60, 8'h05);
        rchk(ADDR_OC_CON, 32'h0000_8006);
        freq <= 1'b0;
        wr(ADDR_OC_CON, 32'h0000_8004);
        wait_pin(1'b1);
        wait_pin(1'b0);
        window(50);
        near({16'h0, hi}, 32'h0, 8'h00);
        wr(ADDR_OC_CON, 32'h0000_8005);
        window(100);
        near({16'h0, hi}, 32'd40, 8'h05);
        wr(ADDR_OC_CON, 32'h0000_8000);
        window(50);
        near({16'h0, hi}, 32'h0, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire

//--- tb/toc_monitor.sv
/* Port checker for toc_top.
   Bound to every toc_top; sees only its ports, one clock. */
`timescale 1ns/100ps
`default_nettype none
module toc_monitor
    import toc_pkg::*;
(
    input wire logic              ref_clk_i,
    input wire logic              rstn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic              wr_en_i,
    input wire logic              rd_en_i,
    input wire logic [DATA_W-1:0] rd_data_o,
    input wire logic              compare_out_o,
    input wire logic              compare_oe_o
);
    logic [HALF_W-1:0] sh_reg;
    logic              act;
    logic              hi_mode;
    logic              lo_mode;
    // Shadow of the writable compare control bits
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_reg <= HALF_ZERO;
        end else if (wr_en_i && addr_i == ADDR_OC_CON) begin
            sh_reg <= wr_data_i[HALF_W-1:0] & OCCON_MASK;
        end
    end
    assign act     = sh_reg[BIT_ON] && (sh_reg[2:0] != OCM_OFF);
    assign hi_mode = sh_reg[BIT_ON] && (sh_reg[2:0] == OCM_SET_LOW);
    assign lo_mode = sh_reg[BIT_ON] && (sh_reg[2:0] == OCM_SET_HIGH);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_oe; compare_oe_o == act; endproperty
    property p_off_low; (!act)[*3] |-> !compare_out_o; endproperty
    property p_hi_init; $rose(hi_mode) |-> ##[0:1] compare_out_o; endproperty
    property p_lo_init; $rose(lo_mode) |-> ##[0:1] !compare_out_o; endproperty
    property p_flt_zero;
        $past(rd_en_i) && $past(addr_i) == ADDR_OC_CON && $past(sh_reg[2:0]) != OCM_PWM_FLT
        |-> !rd_data_o[BIT_FAULT_FLAG];
    endproperty
    property p_rd_con;
        $past(rd_en_i) && $past(addr_i) == ADDR_OC_CON
        |-> (rd_data_o & 32'hFFFF_FFEF) == {HALF_ZERO, $past(sh_reg)};
    endproperty
    property p_odd;
        $past(rd_en_i) && $past(addr_i) == ADDR_TMR3_CON |-> !rd_data_o[BIT_T32];
    endproperty
    property p_gate;
        $past(rd_en_i) && ($past(addr_i) == ADDR_TMR2_CON || $past(addr_i) == ADDR_TMR3_CON)
        && rd_data_o[BIT_TCS] |-> !rd_data_o[BIT_GATE_ACCUMULATE];
    endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    a_off_low: assert property (p_off_low) else $error("pin active while off");
    a_hi_init: assert property (p_hi_init) else $error("pin not set high");
    a_lo_init: assert property (p_lo_init) else $error("pin not set low");
    a_flt_zero: assert property (p_flt_zero) else $error("fault flag outside mode 7");
    a_rd_con: assert property (p_rd_con) else $error("compare control readback");
    a_odd: assert property (p_odd) else $error("odd timer pair bit set");
    a_gate: assert property (p_gate) else $error("gate bit read with ext clock");
    c_hi: cover property (hi_mode ##1 !compare_out_o);
    c_flt: cover property ($past(rd_en_i) && rd_data_o[BIT_FAULT_FLAG]);
    c_act: cover property (act && $rose(compare_out_o));
endmodule
bind toc_top toc_monitor mon_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .compare_out_o(compare_out_o), .compare_oe_o(compare_oe_o));
`default_nettype wire

//--- tb/toc_pin_model.sv
/* Pin load with pull-down and fault source.
   Assumes the bench clock; counts cycles the pin is high. */
`timescale 1ns/100ps
`default_nettype none
module toc_pin_model (
    input  wire logic        ref_clk_i,
    input  wire logic        out_i,
    input  wire logic        oe_i,
    input  wire logic        fault_req_i,
    input  wire logic        clr_i,
    output logic             fault_n_o,
    output logic             pin_o,
    output logic [15:0]      hi_cnt_o
);
    // Released pin falls to the pull-down level
    assign pin_o     = oe_i ? out_i : 1'b0;
    assign fault_n_o = !fault_req_i;
    always_ff @(posedge ref_clk_i) begin
        if (clr_i) begin
            hi_cnt_o <= 16'h0000;
        end else if (pin_o) begin
            hi_cnt_o <= hi_cnt_o + 16'h0001;
        end
    end
endmodule
`default_nettype wire

//--- verilog/toc_pkg.sv
/*
 * Constants for the timer pair and output compare block: register byte
 * addresses, control field positions, write masks, reset values, mode codes.
 * Assumes a plain register port with byte addresses of 8 bits and 32-bit data.
 */
`default_nettype none
package toc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_TMR2_CON = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_TMR2_CNT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_TMR2_PER = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_TMR3_CON = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_TMR3_CNT = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_TMR3_PER = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_OC_CON   = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_OC_PRI   = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_OC_SEC   = 8'h28;

    // Shared control bit positions
    localparam int BIT_ON    = 15;
    localparam int BIT_IDLE_STOP  = 13;
    // Timer control fields
    localparam int BIT_GATE_ACCUMULATE = 7;
    localparam int PS_LSB    = 4;
    localparam int PS_W      = 3;
    localparam int BIT_T32   = 3;
    localparam int BIT_TCS   = 1;
    // Compare control fields
    localparam int BIT_COMPARE_32BIT  = 5;
    localparam int BIT_FAULT_FLAG = 4;
    localparam int BIT_OCSEL = 3;
    localparam int OCM_LSB   = 0;
    localparam int OCM_W     = 3;

    // Writable bits of each control register
    localparam logic [HALF_W-1:0] TCON_MASK_EVEN = 16'hA0FA;
    localparam logic [HALF_W-1:0] TCON_MASK_ODD  = 16'hA0F2;
    localparam logic [HALF_W-1:0] OCCON_MASK     = 16'hA02F;

    // Reset values
    localparam logic [HALF_W-1:0] CON_RST = 16'h0000;
    localparam logic [HALF_W-1:0] CNT_RST = 16'h0000;
    localparam logic [HALF_W-1:0] PER_RST = 16'hFFFF;
    localparam logic [DATA_W-1:0] CMP_RST = 32'h0000_0000;
    localparam logic [7:0]        PRE_RST = 8'h00;
    localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    // Compare mode codes
    localparam logic [OCM_W-1:0] OCM_OFF      = 3'h0;
    localparam logic [OCM_W-1:0] OCM_SET_HIGH = 3'h1;
    localparam logic [OCM_W-1:0] OCM_SET_LOW  = 3'h2;
    localparam logic [OCM_W-1:0] OCM_TOGGLE   = 3'h3;
    localparam logic [OCM_W-1:0] OCM_SINGLE   = 3'h4;
    localparam logic [OCM_W-1:0] OCM_CONT     = 3'h5;
    localparam logic [OCM_W-1:0] OCM_PWM      = 3'h6;
    localparam logic [OCM_W-1:0] OCM_PWM_FLT  = 3'h7;

    // Last prescaler count for each prescale_select code
    localparam logic [7:0] PS_MAX [0:7] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'hFF};

    localparam int SYNC_W = 3;

    typedef enum logic [1:0] {PULSE_WAIT_RISE, PULSE_WAIT_FALL, PULSE_DONE} toc_pulse_t;

endpackage
`default_nettype wire

//--- verilog/toc_top.sv
/*
 * Two 16-bit timers (timer two, timer three) that may pair into one 32-bit
 * timer, plus one output compare unit driving a pin, with a register port.
 * Assumes one 40 MHz clock; the external clock, gate and fault pins are
 * asynchronous and are synchronised here; idle_mode_i is on the same clock.
 */
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module toc_top
    import toc_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              wr_en_i,
    input  wire logic              rd_en_i,
    output logic      [DATA_W-1:0] rd_data_o,
    input  wire logic              idle_mode_i,
    input  wire logic              ext_clk_i,
    input  wire logic              gate_i,
    input  wire logic              fault_n_i,
    output logic                   compare_out_o,
    output logic                   compare_oe_o
);

    function automatic logic [7:0] prescale_last(input logic [PS_W-1:0] sel);
        return PS_MAX[sel];
    endfunction

    function automatic logic [DATA_W-1:0] cmp_width(input logic [DATA_W-1:0] v, input logic wide);
        return wide ? v : {HALF_ZERO, v[HALF_W-1:0]};
    endfunction

    logic [HALF_W-1:0] tcon_reg [0:1];
    logic [HALF_W-1:0] cnt_reg  [0:1];
    logic [HALF_W-1:0] per_reg  [0:1];
    logic [HALF_W-1:0] cnt_next [0:1];
    logic [7:0]        pre_reg  [0:1];
    logic [HALF_W-1:0] ctl      [0:1];
    logic [1:0]        step;
    logic [1:0]        inc;
    logic [1:0]        wrap;
    logic              paired;
    logic [SYNC_W-1:0] ext_sync_reg;
    logic [1:0]        gate_sync_reg;
    logic [1:0]        flt_sync_reg;
    logic              ext_rise;
    logic              fault_act;

    logic [HALF_W-1:0] ccon_reg;
    logic [DATA_W-1:0] pri_reg;
    logic [DATA_W-1:0] sec_reg;
    logic              adv_reg;
    logic              restart_reg;
    logic              last_on_reg;
    logic [OCM_W-1:0]  last_mode_reg;
    logic              out_reg;
    logic              flt_reg;
    toc_pulse_t        pulse_reg;
    logic [OCM_W-1:0]  mode;
    logic              oc_on;
    logic              oc_run;
    logic              oc_init;
    logic [DATA_W-1:0] base;
    logic              match_pri;
    logic              match_sec;
    logic [DATA_W-1:0] rd_next;
    logic [DATA_W-1:0] rd_data_reg;

    // Pin synchronisers
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_sync_reg  <= '0;
            gate_sync_reg <= '0;
            flt_sync_reg  <= '1;
        end else begin
            ext_sync_reg  <= {ext_sync_reg[SYNC_W-2:0], ext_clk_i};
            gate_sync_reg <= {gate_sync_reg[0], gate_i};
            flt_sync_reg  <= {flt_sync_reg[0], fault_n_i};
        end
    end

    assign ext_rise  = ext_sync_reg[1] & ~ext_sync_reg[2];
    assign fault_act = ~flt_sync_reg[1];
    assign paired    = tcon_reg[0][BIT_T32];

    // Timer control and counting
    always_comb begin
        logic [2*HALF_W-1:0] c32;
        logic [2*HALF_W-1:0] p32;
        c32 = {cnt_reg[1], cnt_reg[0]};
        p32 = {per_reg[1], per_reg[0]};
        for (int i = 0; i < 2; i++) begin
            ctl[i]  = (i == 1 && paired) ? tcon_reg[0] : tcon_reg[i];
            step[i] = ctl[i][BIT_ON]
                      & ~(idle_mode_i & (ctl[i][BIT_IDLE_STOP] | (paired & tcon_reg[1][BIT_IDLE_STOP])))
                      & (ctl[i][BIT_TCS] ? ext_rise : 1'b1)
                      & ((ctl[i][BIT_GATE_ACCUMULATE] & ~ctl[i][BIT_TCS]) ? gate_sync_reg[1] : 1'b1);
            inc[i]  = step[i] & (pre_reg[i] >= prescale_last(ctl[i][PS_LSB +: PS_W]));
        end
        if (paired) begin
            inc[1]  = inc[0];
            wrap[0] = inc[0] & (c32 == p32);
            wrap[1] = wrap[0];
            c32     = wrap[0] ? '0 : (inc[0] ? c32 + 32'h0000_0001 : c32);
            cnt_next[0] = c32[HALF_W-1:0];
            cnt_next[1] = c32[2*HALF_W-1:HALF_W];
        end else begin
            for (int i = 0; i < 2; i++) begin
                wrap[i]     = inc[i] & (cnt_reg[i] == per_reg[i]);
                cnt_next[i] = wrap[i] ? CNT_RST : (inc[i] ? cnt_reg[i] + 16'h0001 : cnt_reg[i]);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 2; i++) begin
                tcon_reg[i] <= CON_RST;
                cnt_reg[i]  <= CNT_RST;
                per_reg[i]  <= PER_RST;
                pre_reg[i]  <= PRE_RST;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                cnt_reg[i] <= cnt_next[i];
                if (!ctl[i][BIT_ON] || inc[i]) begin
                    pre_reg[i] <= PRE_RST;
                end else if (step[i]) begin
                    pre_reg[i] <= pre_reg[i] + 8'h01;
                end
            end
            if (wr_en_i) begin
                unique case (addr_i)
                    ADDR_TMR2_CON: tcon_reg[0] <= wr_data_i[HALF_W-1:0] & TCON_MASK_EVEN;
                    ADDR_TMR3_CON: tcon_reg[1] <= wr_data_i[HALF_W-1:0] & TCON_MASK_ODD;
                    ADDR_TMR2_CNT: cnt_reg[0]  <= wr_data_i[HALF_W-1:0];
                    ADDR_TMR3_CNT: cnt_reg[1]  <= wr_data_i[HALF_W-1:0];
                    ADDR_TMR2_PER: per_reg[0]  <= wr_data_i[HALF_W-1:0];
                    ADDR_TMR3_PER: per_reg[1]  <= wr_data_i[HALF_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // Compare time base and match detection
    assign mode    = ccon_reg[OCM_LSB +: OCM_W];
    assign oc_on   = ccon_reg[BIT_ON];
    assign oc_run  = oc_on & ~(idle_mode_i & ccon_reg[BIT_IDLE_STOP]);
    assign oc_init = oc_on & (~last_on_reg | (mode != last_mode_reg));
    assign base    = ccon_reg[BIT_COMPARE_32BIT] ? {cnt_reg[1], cnt_reg[0]}
                   : {HALF_ZERO, ccon_reg[BIT_OCSEL] ? cnt_reg[1] : cnt_reg[0]};
    assign match_pri = adv_reg & (base == cmp_width(pri_reg, ccon_reg[BIT_COMPARE_32BIT]));
    assign match_sec = adv_reg & (base == cmp_width(sec_reg, ccon_reg[BIT_COMPARE_32BIT]));

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            adv_reg       <= 1'b0;
            restart_reg   <= 1'b0;
            last_on_reg   <= 1'b0;
            last_mode_reg <= OCM_OFF;
        end else begin
            adv_reg       <= (ccon_reg[BIT_COMPARE_32BIT] || !ccon_reg[BIT_OCSEL]) ? inc[0] : inc[1];
            restart_reg   <= (ccon_reg[BIT_COMPARE_32BIT] || !ccon_reg[BIT_OCSEL]) ? wrap[0] : wrap[1];
            last_on_reg   <= oc_on;
            last_mode_reg <= mode;
        end
    end

    // Compare control registers
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ccon_reg <= CON_RST;
            pri_reg  <= CMP_RST;
            sec_reg  <= CMP_RST;
        end else if (wr_en_i) begin
            unique case (addr_i)
                ADDR_OC_CON: ccon_reg <= wr_data_i[HALF_W-1:0] & OCCON_MASK;
                ADDR_OC_PRI: pri_reg  <= wr_data_i;
                ADDR_OC_SEC: sec_reg  <= wr_data_i;
                default: ;
            endcase
        end
    end

    // Fault flag, hardware set and clear
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flt_reg <= 1'b0;
        end else if (!oc_on || mode != OCM_PWM_FLT) begin
            flt_reg <= 1'b0;
        end else if (oc_run && fault_act) begin
            flt_reg <= 1'b1;
        end else if (oc_run && restart_reg) begin
            flt_reg <= 1'b0;
        end
    end

    // Output pin sequencing
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_reg   <= 1'b0;
            pulse_reg <= PULSE_WAIT_RISE;
        end else if (!oc_on || mode == OCM_OFF) begin
            out_reg   <= 1'b0;
            pulse_reg <= PULSE_WAIT_RISE;
        end else if (oc_init) begin
            out_reg   <= (mode == OCM_SET_LOW);
            pulse_reg <= PULSE_WAIT_RISE;
        end else if (oc_run) begin
            unique case (mode)
                OCM_SET_HIGH: if (match_pri) out_reg <= 1'b1;
                OCM_SET_LOW:  if (match_pri) out_reg <= 1'b0;
                OCM_TOGGLE:   if (match_pri) out_reg <= ~out_reg;
                OCM_SINGLE, OCM_CONT: begin
                    unique case (pulse_reg)
                        PULSE_WAIT_RISE: begin
                            if (match_pri) begin
                                out_reg   <= 1'b1;
                                pulse_reg <= PULSE_WAIT_FALL;
                            end
                        end
                        PULSE_WAIT_FALL: begin
                            if (match_sec) begin
                                out_reg   <= 1'b0;
                                pulse_reg <= (mode == OCM_CONT) ? PULSE_WAIT_RISE : PULSE_DONE;
                            end
                        end
                        PULSE_DONE: ;
                        default: pulse_reg <= PULSE_DONE;
                    endcase
                end
                OCM_PWM, OCM_PWM_FLT: begin
                    if (mode == OCM_PWM_FLT && (fault_act || flt_reg) && !(restart_reg && !fault_act)) begin
                        out_reg <= 1'b0;
                    end else if (match_sec) begin
                        out_reg <= 1'b0;
                    end else if (restart_reg) begin
                        out_reg <= 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    assign compare_out_o = out_reg;
    assign compare_oe_o  = oc_on && mode != OCM_OFF;

    // Register read port, data one cycle after the strobe
    always_comb begin
        rd_next = WORD_ZERO;
        unique case (addr_i)
            ADDR_TMR2_CON: rd_next[HALF_W-1:0] = tcon_reg[0] & ~(HALF_W'(tcon_reg[0][BIT_TCS]) << BIT_GATE_ACCUMULATE);
            ADDR_TMR3_CON: rd_next[HALF_W-1:0] = tcon_reg[1] & ~(HALF_W'(tcon_reg[1][BIT_TCS]) << BIT_GATE_ACCUMULATE);
            ADDR_TMR2_CNT: rd_next[HALF_W-1:0] = cnt_reg[0];
            ADDR_TMR3_CNT: rd_next[HALF_W-1:0] = cnt_reg[1];
            ADDR_TMR2_PER: rd_next[HALF_W-1:0] = per_reg[0];
            ADDR_TMR3_PER: rd_next[HALF_W-1:0] = per_reg[1];
            ADDR_OC_CON: begin
                rd_next[HALF_W-1:0] = ccon_reg;
                rd_next[BIT_FAULT_FLAG]  = flt_reg & (mode == OCM_PWM_FLT);
            end
            ADDR_OC_PRI:   rd_next = pri_reg;
            ADDR_OC_SEC:   rd_next = sec_reg;
            default: ;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_reg <= WORD_ZERO;
        end else begin
            rd_data_reg <= rd_en_i ? rd_next : WORD_ZERO;
        end
    end

    assign rd_data_o = rd_data_reg;

endmodule
`default_nettype wire
